// ==== rtl/ocft_pkg.sv ====
`default_nettype none
package ocft_pkg;
	// Clock and timing
	localparam int unsigned CLK_HZ          = 40_000_000;
	localparam int unsigned HICCUP_MS       = 20;
	localparam int unsigned HICCUP_CYCLES   = CLK_HZ / 1000 * HICCUP_MS;
	localparam int unsigned SAMPLE_NS       = 75;
	localparam int unsigned SAMPLE_CYCLES_R = SAMPLE_NS * CLK_HZ / 1_000_000_000;
	localparam int unsigned SAMPLE_CYCLES   =
		(SAMPLE_CYCLES_R < 1) ? 1 : SAMPLE_CYCLES_R;

	// Over-current counts
	localparam logic [3:0] OC_TOTAL_DEF   = 4'h8;
	localparam logic [1:0] OC_STEP_RUN    = 2'h3;
	localparam logic [2:0] OC_RECOVER_RUN = 3'h4;

	// Default current threshold in 1/4 A codes (30 A)
	localparam logic [7:0] OC_LIMIT_DEF = 8'h78;

	// Temperature: byte value plus offset gives degrees C
	localparam logic [7:0] TEMP_OFFSET_C = 8'h28;
	localparam logic [7:0] OT_LIMIT_DEF  = 8'h7d;
	localparam logic [7:0] OT_HYST_C     = 8'h19;
	localparam logic [7:0] TEMP_RES_C    = 8'h0a;

	// Duty cap levels, coded as eighths of the period
	localparam logic [3:0] DUTY_NOMINAL = 4'h8;
	localparam logic [3:0] DUTY_HALF    = 4'h4;
	localparam logic [3:0] DUTY_QUARTER = 4'h2;
	localparam logic [3:0] DUTY_EIGHTH  = 4'h1;

	typedef enum logic [1:0] {
		OCFT_OC_LATCH,
		OCFT_OC_HICCUP,
		OCFT_OC_CONST
	} ocft_oc_resp_t;

	typedef enum logic [1:0] {
		OCFT_OT_IGNORE,
		OCFT_OT_RESTART,
		OCFT_OT_LATCH
	} ocft_ot_resp_t;

	typedef struct packed {
		logic [7:0]    oc_limit;
		logic [7:0]    oc_warn_limit;
		logic [3:0]    oc_total_max;
		ocft_oc_resp_t oc_resp;
		logic [7:0]    ot_limit;
		ocft_ot_resp_t ot_resp;
	} ocft_cfg_t;

	typedef struct packed {
		logic       conv_en;
		logic       hiccup;
		logic       oc_latched;
		logic       ot_fault;
		logic       ot_latched;
		logic       oc_warn;
		logic [3:0] duty_cap;
	} ocft_stat_t;
endpackage
`default_nettype wire

// ==== rtl/ocft_top.sv ====
// Behaviour
// - Default: eight cumulative comparator-trip cycles start a hiccup.
// - Hiccup holds conversion enable low for 20 ms before restart.
// - After hiccup, clear trip state and restart; repeat while overload lasts.
// - Host programs the over-current threshold; any code accepted. Here cfg_i.oc_limit drives nothing.
// - Response selector picks latched shutdown or hiccup after eight cycles.
// - Trip while duty already below one eighth adds no duty limiting.
// - Constant-current mode caps duty 1/2, 1/4, 1/8 per three trips.
// - At one-eighth cap, keep switching until total reaches max, then hiccup.
// - Four clean cycles in a row double the cap back toward nominal.
// - Current telemetry byte saturates at full scale instead of wrapping.
// - Trip detection uses only the comparator, never the telemetry code.
// - Warning compares digitized current with threshold.
// - Management-bus temperature readout has 10 degree resolution.
// - Temperature byte is one-degree steps offset by forty degrees.
// - Over-temperature threshold resets to 125 C and is host writable.
// - Default over-temperature response drops conversion enable.
// - Auto restart only after falling 25 degrees below the threshold.
// - Over-temperature response: ignore, auto restart, or latched shutdown.
// - Sample comparator 75 ns after rising edge of the set pulse.
// - Current byte reports average current in quarter-amp steps.
`timescale 1ns/1ps
`default_nettype none

module ocft_top #(
	parameter int unsigned HICCUP_LEN = ocft_pkg::HICCUP_CYCLES
) (
	input  wire logic              clock_i,
	input  wire logic              rst_n_i,
	input  wire logic              enable_i,
	input  wire logic              op_on_i,
	input  wire ocft_pkg::ocft_cfg_t cfg_i,
	input  wire logic              set_pulse_i,
	input  wire logic              overcurrent_trip_i,
	input  wire logic [3:0]        duty_now_i,
	input  wire logic [9:0]        iout_raw_i,
	input  wire logic [7:0]        temp_c_i,
	output logic                   conv_en_o,
	output logic [3:0]             duty_cap_o,
	output logic [7:0]             output_current_byte_o,
	output logic [7:0]             die_temperature_byte_o,
	output logic [7:0]             temp_read_o,
	output ocft_pkg::ocft_stat_t   status_o
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] cap_down(input logic [3:0] c);
		cap_down = (c > ocft_pkg::DUTY_EIGHTH) ? (c >> 1) : c;
	endfunction

	function automatic logic [3:0] cap_up(input logic [3:0] c);
		cap_up = (c < ocft_pkg::DUTY_NOMINAL) ? (c << 1) : c;
	endfunction

	logic [7:0] cyc_c;
	assign cyc_c = 8'(ocft_pkg::SAMPLE_CYCLES);

	// Rising edge of a level seen against its registered copy
	function automatic logic rise(input logic now, input logic was);
		rise = now && !was;
	endfunction

	// ------------------------------------------------------------
	// Latch release
	// ------------------------------------------------------------
	// Off-then-on command and enable edges release latches. The copies
	// reset high so a level already high at release is no fresh edge.
	logic       enable_q;
	logic       op_on_q;
	logic       rearm;
	assign rearm = rise(enable_i, enable_q) || rise(op_on_i, op_on_q);

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			enable_q <= 1'b1;
		end else begin
			enable_q <= enable_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			op_on_q <= 1'b1;
		end else begin
			op_on_q <= op_on_i;
		end
	end

	// ------------------------------------------------------------
	// Comparator sampling window
	// ------------------------------------------------------------
	// Counts from the set pulse rising edge so switching noise near
	// the edge is skipped; only the comparator is used, never the ADC.
	logic       set_q;
	logic [7:0] win_q;
	logic       sample;
	logic       trip_cyc;

	// Set pulse idles low, so a low reset value gives no false edge
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			set_q <= 1'b0;
		end else begin
			set_q <= set_pulse_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			win_q <= 8'h00;
		end else begin
			if (rise(set_pulse_i, set_q)) begin
				win_q <= cyc_c;
			end else if (win_q != 8'h00) begin
				win_q <= win_q - 8'h01;
			end
		end
	end

	assign sample   = (win_q == 8'h01);
	assign trip_cyc = sample && overcurrent_trip_i;

	// ------------------------------------------------------------
	// Over-current sequencer
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		OC_RUN,
		OC_HICCUP,
		OC_LATCHED
	} ocft_oc_state_t;

	ocft_oc_state_t oc_state_q;
	logic [3:0]     total_q;
	logic [1:0]     run_q;
	logic [2:0]     clean_q;
	logic [3:0]     cap_q;
	logic [31:0]    hic_q;
	logic           total_hit;
	logic           step_en;

	assign total_hit = trip_cyc &&
		(total_q + 4'h1 >= cfg_i.oc_total_max);
	// Stepping only in constant-current mode and while duty is
	// not already at or below one eighth
	assign step_en = (cfg_i.oc_resp == ocft_pkg::OCFT_OC_CONST) &&
		(duty_now_i > ocft_pkg::DUTY_EIGHTH);

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			oc_state_q <= OC_RUN;
			total_q    <= 4'h0;
			run_q      <= 2'h0;
			clean_q    <= 3'h0;
			cap_q      <= ocft_pkg::DUTY_NOMINAL;
			hic_q      <= 32'h0;
		end else begin
			case (oc_state_q)
			OC_RUN: begin
				if (total_hit) begin
					total_q <= 4'h0;
					run_q   <= 2'h0;
					clean_q <= 3'h0;
					if (cfg_i.oc_resp == ocft_pkg::OCFT_OC_LATCH) begin
						oc_state_q <= OC_LATCHED;
					end else begin
						oc_state_q <= OC_HICCUP;
						hic_q      <= 32'(HICCUP_LEN);
					end
				end else if (trip_cyc) begin
					total_q <= total_q + 4'h1;
					clean_q <= 3'h0;
					if (step_en && run_q + 2'h1 == ocft_pkg::OC_STEP_RUN) begin
						run_q <= 2'h0;
						cap_q <= cap_down(cap_q);
					end else begin
						run_q <= run_q + 2'h1;
					end
				end else if (sample) begin
					run_q <= 2'h0;
					if (clean_q + 3'h1 == ocft_pkg::OC_RECOVER_RUN) begin
						clean_q <= 3'h0;
						cap_q   <= cap_up(cap_q);
					end else begin
						clean_q <= clean_q + 3'h1;
					end
				end
			end
			OC_HICCUP: begin
				if (hic_q <= 32'h1) begin
					// Fresh start: counts and cap cleared
					oc_state_q <= OC_RUN;
					cap_q      <= ocft_pkg::DUTY_NOMINAL;
				end else begin
					hic_q <= hic_q - 32'h1;
				end
			end
			OC_LATCHED: begin
				if (rearm) begin
					oc_state_q <= OC_RUN;
					cap_q      <= ocft_pkg::DUTY_NOMINAL;
				end
			end
			default: oc_state_q <= OC_RUN;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Over-temperature
	// ------------------------------------------------------------
	logic [7:0] temp_c_q;
	logic       ot_fault_q;
	logic       ot_latch_q;
	logic [8:0] ot_low;
	logic       ot_over;

	// A limit below the hysteresis band borrows; then any reading not over the limit clears
	assign ot_low  = {1'b0, cfg_i.ot_limit} - {1'b0, ocft_pkg::OT_HYST_C};
	assign ot_over = temp_c_q > cfg_i.ot_limit;

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			temp_c_q <= 8'h00;
		end else begin
			temp_c_q <= temp_c_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			ot_fault_q <= 1'b0;
		end else begin
			if (ot_over) begin
				ot_fault_q <= 1'b1;
			end else if (ot_low[8] || {1'b0, temp_c_q} <= ot_low) begin
				ot_fault_q <= 1'b0;
			end
		end
	end

	// A fresh trip wins over a release in the same cycle
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			ot_latch_q <= 1'b0;
		end else begin
			if (ot_over && cfg_i.ot_resp == ocft_pkg::OCFT_OT_LATCH) begin
				ot_latch_q <= 1'b1;
			end else if (rearm) begin
				ot_latch_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs and telemetry
	// ------------------------------------------------------------
	// Ignore mode never stops conversion; restart mode follows the
	// live fault, latched mode the latch
	logic ot_block;
	assign ot_block = ot_latch_q ||
		(ot_fault_q && cfg_i.ot_resp == ocft_pkg::OCFT_OT_RESTART);

	// One term feeds the pin and its status copy, so they never differ
	logic run_ok;
	assign run_ok = enable_i && (oc_state_q == OC_RUN) && !ot_block;

	logic [7:0] iout_byte;
	// Raw code is in 1/16 A; dropping two bits gives 1/4 A, clamped
	assign iout_byte = (iout_raw_i[9:2] > 8'hfe) ? 8'hff
		: iout_raw_i[9:2];

	logic [7:0] t_byte;
	assign t_byte = (temp_c_q < ocft_pkg::TEMP_OFFSET_C) ? 8'h00
		: temp_c_q - ocft_pkg::TEMP_OFFSET_C;

	logic [7:0] t_tens;
	assign t_tens = temp_c_q - (temp_c_q % ocft_pkg::TEMP_RES_C);

	// ------------------------------------------------------------
	// Enable and duty cap
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			conv_en_o  <= 1'b0;
			duty_cap_o <= ocft_pkg::DUTY_NOMINAL;
		end else begin
			conv_en_o  <= run_ok;
			duty_cap_o <= cap_q;
		end
	end

	// ------------------------------------------------------------
	// Telemetry bytes
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			output_current_byte_o  <= 8'h00;
			die_temperature_byte_o <= 8'h00;
			temp_read_o            <= 8'h00;
		end else begin
			output_current_byte_o  <= iout_byte;
			die_temperature_byte_o <= t_byte;
			temp_read_o            <= t_tens;
		end
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			status_o <= '0;
		end else begin
			status_o.conv_en    <= run_ok;
			status_o.hiccup     <= oc_state_q == OC_HICCUP;
			status_o.oc_latched <= oc_state_q == OC_LATCHED;
			status_o.ot_fault   <= ot_fault_q;
			status_o.ot_latched <= ot_latch_q;
			status_o.oc_warn    <= iout_byte >= cfg_i.oc_warn_limit;
			status_o.duty_cap   <= cap_q;
		end
	end

	// Threshold is not passed on; it only feeds the otherwise unused unused_limit
	logic [7:0] unused_limit;
	assign unused_limit = cfg_i.oc_limit;

endmodule

`default_nettype wire

// ==== dv/ocft_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Port checks
// ------------------------------
module ocft_properties #(
	parameter int unsigned HICCUP_LEN = 50
) (
	input wire logic                 clock_i,
	input wire logic                 rst_n_i,
	input wire ocft_pkg::ocft_cfg_t  cfg_i,
	input wire logic [7:0]           temp_c_i,
	input wire logic [9:0]           iout_raw_i,
	input wire logic                 conv_en_o,
	input wire logic [7:0]           output_current_byte_o,
	input wire logic [7:0]           die_temperature_byte_o,
	input wire logic [7:0]           temp_read_o,
	input wire ocft_pkg::ocft_stat_t status_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	int unsigned hic_n;
	always_ff @(posedge clock_i)
		hic_n <= status_o.hiccup ? hic_n + 1 : 0;
	sequence s_hot;
		cfg_i.ot_resp == ocft_pkg::OCFT_OT_RESTART
			&& temp_c_i > cfg_i.ot_limit;
	endsequence
	property p_die;
		$past(rst_n_i) && $past(rst_n_i, 2) |-> die_temperature_byte_o ==
			($past(temp_c_i, 2) < 8'h28 ? 8'h00
			: $past(temp_c_i, 2) - 8'h28);
	endproperty
	a_die: assert property (p_die) else $error("die byte");
	property p_trd;
		$past(rst_n_i) && $past(rst_n_i, 2) |->
			temp_read_o == $past(temp_c_i, 2) / 8'h0a * 8'h0a;
	endproperty
	a_trd: assert property (p_trd) else $error("temp read");
	property p_iout;
		$past(rst_n_i) |-> output_current_byte_o == $past(iout_raw_i[9:2]);
	endproperty
	a_iout: assert property (p_iout) else $error("current byte");
	property p_ot_off;
		s_hot [*4] |-> !conv_en_o;
	endproperty
	a_ot_off: assert property (p_ot_off) else $error("hot but on");
	property p_ot_hold;
		status_o.ot_fault && !conv_en_o
			&& temp_c_i > cfg_i.ot_limit - 8'h19 |=> !conv_en_o;
	endproperty
	a_ot_hold: assert property (p_ot_hold) else $error("early restart");
	property p_oc_lat;
		status_o.oc_latched [*2] |-> !conv_en_o;
	endproperty
	a_oc_lat: assert property (p_oc_lat) else $error("latch but on");
	property p_hic_off;
		status_o.hiccup [*3] |-> !conv_en_o;
	endproperty
	a_hic_off: assert property (p_hic_off) else $error("hiccup on");
	property p_hic_len;
		$fell(status_o.hiccup) |-> hic_n >= HICCUP_LEN;
	endproperty
	a_hic_len: assert property (p_hic_len) else $error("hiccup short");
endmodule
`default_nettype wire

// ==== dv/ocft_stage_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Switching stage model
// ------------------------------
module ocft_stage_model #(
	parameter int unsigned PERIOD = 16
) (
	input  wire logic       clock_i,
	input  wire logic       overload_i,
	input  wire logic [3:0] duty_cap_i,
	input  wire logic [3:0] duty_req_i,
	output logic            set_pulse_o,
	output logic            trip_o,
	output logic [3:0]      duty_now_o
);
	int unsigned ph = 0;
	initial {set_pulse_o, trip_o, duty_now_o} = 6'h08;
	// Comparator held as a level; sampling point is the sequencer's job
	always @(posedge clock_i) begin
		ph <= (ph + 1) % PERIOD;
		set_pulse_o <= #1 ph < PERIOD / 8;
		trip_o <= #1 overload_i;
		duty_now_o <= #1 duty_req_i < duty_cap_i ? duty_req_i : duty_cap_i;
	end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Self-checking bench
// ------------------------------
module testbench;
	localparam int unsigned HLEN = 50;
	localparam int unsigned PER = 16;
	logic                 clock_i = 1'b0;
	logic                 rst_n_i = 1'b0;
	logic                 en = 1'b1;
	logic                 op_on = 1'b1;
	logic                 over = 1'b0;
	logic [3:0]           duty_req = 4'h8;
	logic [9:0]           iout = 10'h000;
	logic [7:0]           temp = 8'h3c;
	logic                 set_p, trip, conv_en;
	logic [3:0]           duty_now, cap;
	logic [7:0]           cur_b, die_b, t_rd;
	logic [31:0]          seed = 32'ha87c;
	logic [3:0]           steps [6] = '{4'h4, 4'h2, 4'h1, 4'h2, 4'h4, 4'h8};
	int                   error_cnt = 0, n_compared = 0, cyc = 0;
	ocft_pkg::ocft_stat_t st;
	ocft_pkg::ocft_cfg_t  cfg = '{8'h78, 8'h78, 4'h8,
		ocft_pkg::OCFT_OC_HICCUP, 8'h7d, ocft_pkg::OCFT_OT_RESTART};
	always #12.5 clock_i = ~clock_i;
	ocft_stage_model #(.PERIOD(PER)) u_stage (.clock_i(clock_i),
		.overload_i(over), .duty_cap_i(cap), .duty_req_i(duty_req),
		.set_pulse_o(set_p), .trip_o(trip), .duty_now_o(duty_now));
	ocft_top #(.HICCUP_LEN(HLEN)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.enable_i(en), .op_on_i(op_on), .cfg_i(cfg), .set_pulse_i(set_p),
		.overcurrent_trip_i(trip), .duty_now_i(duty_now), .iout_raw_i(iout),
		.temp_c_i(temp), .conv_en_o(conv_en), .duty_cap_o(cap),
		.output_current_byte_o(cur_b), .die_temperature_byte_o(die_b),
		.temp_read_o(t_rd), .status_o(st));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [23:0] exp_tel(logic [9:0] i, logic [7:0] t);
		return {i[9:2], (t < 8'h28 ? 8'h00 : t - 8'h28), t / 8'h0a * 8'h0a};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic chk(input logic [23:0] g, e, input string m);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	// Bounded so a stuck design falls through to a failing compare
	task automatic wait_for(input bit on_cap, input logic [3:0] v);
		for (int i = 0; i < 2000
			&& (on_cap ? cap : {3'h0, conv_en}) !== v; i++)
			tick(1);
	endtask
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	initial begin
		tick(8);
		chk({cap, 3'h0, conv_en}, 24'h80, "reset");
		rst_n_i = 1'b1;
		for (int i = 0; i < 30; i++) begin
			void'(xs());
			iout = i == 0 ? 10'h3ff : i == 2 ? 10'h1e4 : seed[9:0];
			temp = i == 1 ? 8'h27 : seed[17:10];
			tick(3);
			chk({cur_b, die_b, t_rd}, exp_tel(iout, temp), "tel");
			if (iout[9:2] != 8'h78)
				chk(st.oc_warn, iout[9:2] > 8'h78, "warn");
		end
		$display("telemetry done");
		temp = 8'h3c;
		wait_for(0, 4'h1);
		over = 1'b1;
		tick(6 * PER);
		chk(conv_en, 1, "early hiccup");
		wait_for(0, 4'h0);
		chk(st.hiccup, 1, "hiccup");
		tick(HLEN - 10);
		chk(conv_en, 0, "hiccup length");
		wait_for(0, 4'h1);
		chk(conv_en, 1, "restart");
		wait_for(0, 4'h0);
		chk(st.hiccup, 1, "repeat");
		over = 1'b0;
		$display("hiccup done");
		cfg.oc_resp = ocft_pkg::OCFT_OC_LATCH;
		for (int k = 0; k < 2; k++) begin
			wait_for(0, 4'h1);
			over = 1'b1;
			wait_for(0, 4'h0);
			over = 1'b0;
			tick(2 * HLEN);
			chk({st.oc_latched, conv_en}, 2'b10, "latched");
			{en, op_on} = k ? 2'b01 : 2'b10;
			tick(2);
			{en, op_on} = 2'b11;
			tick(5);
			chk(conv_en, 1, "released");
		end
		$display("latch done");
		cfg.oc_resp = ocft_pkg::OCFT_OC_CONST;
		cfg.oc_total_max = 4'hf;
		foreach (steps[j]) begin
			over = j < 3;
			wait_for(1, steps[j]);
			chk(cap, steps[j], "cap step");
		end
		duty_req = 4'h1;
		over = 1'b1;
		tick(4 * PER);
		chk(cap, 4'h8, "no limiting");
		wait_for(0, 4'h0);
		chk(st.hiccup, 1, "total reached");
		over = 1'b0;
		duty_req = 4'h8;
		$display("limit done");
		wait_for(0, 4'h1);
		for (int m = 0; m < 3; m++) begin
			cfg.ot_resp = ocft_pkg::ocft_ot_resp_t'(m);
			temp = 8'h7d;
			tick(5);
			chk(conv_en, 1, "at limit");
			temp = 8'h7e;
			tick(5);
			chk(conv_en, m == 0, "hot");
			temp = 8'h65;
			tick(5);
			chk(conv_en, m == 0, "band");
			temp = 8'h64;
			tick(5);
			chk(conv_en, m != 2, "cool");
			op_on = 1'b0;
			tick(2);
			op_on = 1'b1;
			tick(5);
			chk(conv_en, 1, "resume");
		end
		$display("thermal done");
		complete_run();
	end
endmodule
bind ocft_top ocft_properties #(.HICCUP_LEN(HICCUP_LEN)) u_props (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_i(cfg_i),
	.temp_c_i(temp_c_i), .iout_raw_i(iout_raw_i), .conv_en_o(conv_en_o),
	.output_current_byte_o(output_current_byte_o), .status_o(status_o),
	.die_temperature_byte_o(die_temperature_byte_o),
	.temp_read_o(temp_read_o));
`default_nettype wire
